// [logic/far_op_datapath.sv]
// extended data-memory instruction datapath with flags and skip control
// Contract
// - far address reaches any data memory section
// - moves copy byte unchanged, no flags
// - OR to working or memory, zero flag only
// - rotate left, bit 7 into bit 0
// - rotate right, bit 0 into bit 7
// - working-target rotates leave memory untouched
// - rotate left through ripple bit
// - rotate right through ripple bit
// - subtract with borrow updates six flags
// - ripple bit clear on negative, else set
// - borrow subtract to memory keeps working
// - plain subtract into working register
// - plain subtract to memory form
// - skip instructions take three cycles
// - decrement memory, skip on zero
// - increment memory, skip on zero
// - working-target inc/dec skip, memory unchanged
// - all-ones writes FFH, no flags
// - bit set forces only selected bit
// - bit test skips when bit is one
// - nonzero skip rewrites byte, skips nonzero
`timescale 1ns/1ps

module far_op_datapath
   import far_op_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic op_valid,
   output logic op_ready,
   input wire op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [BIT_SEL_W-1:0] op_bit,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_rd,
   input wire logic [DATA_W-1:0] mem_rdata,
   output logic mem_we,
   output logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0] working_register,
   output logic ripple_out_bit,
   output logic nibble_ripple_flag,
   output logic result_null_flag,
   output logic signed_wrap_flag,
   output logic signed_result_flag,
   output logic multi_byte_null_flag,
   output logic skip_next,
   output logic op_done
);

   state_t state_q;
   op_t op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [BIT_SEL_W-1:0] bit_q;
   logic [DATA_W-1:0] work_q;
   logic [FLAG_W-1:0] flags_q;
   logic [DATA_W-1:0] wdata_q;
   logic we_q;
   logic skip_q;
   logic done_q;

   // combinational results of the execute cycle
   logic [DATA_W-1:0] res_d;
   logic [FLAG_W-1:0] flags_d;
   logic to_work_d;
   logic to_mem_d;
   logic skip_d;
   logic is_skip_op;

   logic [DATA_W-1:0] m;
   logic [DATA_W-1:0] bit_mask;
   logic [DATA_W:0] diff9;
   logic [4:0] diff5;
   logic sub_cin;
   logic [DATA_W-1:0] diff;
   logic sub_wrap;

   assign m = mem_rdata;
   assign bit_mask = ONE_BYTE << bit_q;

   always_comb begin
      unique case (op_q)
         far_decrement_skip_zero, far_decrement_skip_zero_to_working,
         far_increment_skip_zero, far_increment_skip_zero_to_working,
         far_bit_skip_set, far_skip_nonzero: is_skip_op = 1'b1;
         default: is_skip_op = 1'b0;
      endcase
   end

   // subtraction as add of complement; carry out means no borrow
   always_comb begin
      if ((op_q == far_subtract_borrow) ||
          (op_q == far_subtract_borrow_to_memory)) begin
         sub_cin = flags_q[FLAG_C];
      end else begin
         sub_cin = 1'b1;
      end
   end

   assign diff9 = {1'b0, work_q} + {1'b0, ~m} + {8'h00, sub_cin};
   assign diff5 = {1'b0, work_q[3:0]} + {1'b0, ~m[3:0]} + {4'h0, sub_cin};
   assign diff = diff9[DATA_W-1:0];
   assign sub_wrap = (work_q[7] != m[7]) && (diff[7] != work_q[7]);

   always_comb begin
      res_d = work_q;
      flags_d = flags_q;
      to_work_d = 1'b0;
      to_mem_d = 1'b0;
      skip_d = 1'b0;
      unique case (op_q)
         far_move_to_working: begin
            res_d = m;
            to_work_d = 1'b1;
         end
         far_move_to_memory: begin
            res_d = work_q;
            to_mem_d = 1'b1;
         end
         far_or_to_working, far_or_to_memory: begin
            res_d = work_q | m;
            flags_d[FLAG_Z] = (res_d == ZERO_BYTE);
            to_work_d = (op_q == far_or_to_working);
            to_mem_d = (op_q == far_or_to_memory);
         end
         far_rotate_left, far_rotate_left_to_working: begin
            res_d = {m[6:0], m[7]};
            to_work_d = (op_q == far_rotate_left_to_working);
            to_mem_d = (op_q == far_rotate_left);
         end
         far_rotate_right, far_rotate_right_to_working: begin
            res_d = {m[0], m[7:1]};
            to_work_d = (op_q == far_rotate_right_to_working);
            to_mem_d = (op_q == far_rotate_right);
         end
         far_rotate_left_thru_ripple,
         far_rotate_left_thru_ripple_to_working: begin
            res_d = {m[6:0], flags_q[FLAG_C]};
            flags_d[FLAG_C] = m[7];
            to_work_d = (op_q == far_rotate_left_thru_ripple_to_working);
            to_mem_d = (op_q == far_rotate_left_thru_ripple);
         end
         far_rotate_right_thru_ripple,
         far_rotate_right_thru_ripple_to_working: begin
            res_d = {flags_q[FLAG_C], m[7:1]};
            flags_d[FLAG_C] = m[0];
            to_work_d = (op_q == far_rotate_right_thru_ripple_to_working);
            to_mem_d = (op_q == far_rotate_right_thru_ripple);
         end
         far_subtract_borrow, far_subtract_borrow_to_memory,
         far_subtract, far_subtract_to_memory: begin
            res_d = diff;
            flags_d[FLAG_C] = diff9[DATA_W];
            flags_d[FLAG_NIB] = diff5[4];
            flags_d[FLAG_Z] = (diff == ZERO_BYTE);
            flags_d[FLAG_WRAP] = sub_wrap;
            flags_d[FLAG_SIGN] = sub_wrap ^ diff[7];
            // chained zero only for the borrow forms
            if ((op_q == far_subtract_borrow) ||
                (op_q == far_subtract_borrow_to_memory)) begin
               flags_d[FLAG_MBZ] = (diff == ZERO_BYTE) && flags_q[FLAG_MBZ];
            end else begin
               flags_d[FLAG_MBZ] = (diff == ZERO_BYTE);
            end
            to_work_d = (op_q == far_subtract_borrow) ||
                        (op_q == far_subtract);
            to_mem_d = (op_q == far_subtract_borrow_to_memory) ||
                       (op_q == far_subtract_to_memory);
         end
         far_decrement_skip_zero, far_decrement_skip_zero_to_working: begin
            res_d = m - ONE_BYTE;
            skip_d = (res_d == ZERO_BYTE);
            to_work_d = (op_q == far_decrement_skip_zero_to_working);
            to_mem_d = (op_q == far_decrement_skip_zero);
         end
         far_increment_skip_zero, far_increment_skip_zero_to_working: begin
            res_d = m + ONE_BYTE;
            skip_d = (res_d == ZERO_BYTE);
            to_work_d = (op_q == far_increment_skip_zero_to_working);
            to_mem_d = (op_q == far_increment_skip_zero);
         end
         far_all_ones: begin
            res_d = ALL_ONES;
            to_mem_d = 1'b1;
         end
         far_bit_set: begin
            res_d = m | bit_mask;
            to_mem_d = 1'b1;
         end
         far_bit_skip_set: begin
            skip_d = |(m & bit_mask);
         end
         far_skip_nonzero: begin
            res_d = m;
            to_mem_d = 1'b1;
            skip_d = (m != ZERO_BYTE);
         end
         default: begin
            res_d = work_q;
         end
      endcase
   end

   // sequencer: fetch, execute, and a dummy cycle for skip ops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (op_valid) begin
                  state_q <= S_FETCH;
               end
            end
            S_FETCH: begin
               state_q <= S_EXEC;
            end
            S_EXEC: begin
               state_q <= is_skip_op ? S_DUMMY : S_IDLE;
            end
            S_DUMMY: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // operand capture; full address selects any memory section
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= far_move_to_working;
         addr_q <= '0;
         bit_q <= '0;
      end else if ((state_q == S_IDLE) && op_valid) begin
         op_q <= op_code;
         addr_q <= op_addr;
         bit_q <= op_bit;
      end
   end

   // architectural state commits only in the execute cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_q <= WORK_RST;
         flags_q <= FLAGS_RST;
      end else if (state_q == S_EXEC) begin
         flags_q <= flags_d;
         if (to_work_d) begin
            work_q <= res_d;
         end
      end
   end

   // memory write strobe and data, registered from execute
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         we_q <= 1'b0;
         wdata_q <= ZERO_BYTE;
      end else begin
         we_q <= (state_q == S_EXEC) && to_mem_d;
         if ((state_q == S_EXEC) && to_mem_d) begin
            wdata_q <= res_d;
         end
      end
   end

   // skip indication and completion pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         skip_q <= (state_q == S_EXEC) && skip_d;
         done_q <= ((state_q == S_EXEC) && !is_skip_op) ||
                   (state_q == S_DUMMY);
      end
   end

   assign op_ready = (state_q == S_IDLE);
   assign mem_rd = (state_q == S_FETCH);
   assign mem_addr = addr_q;
   assign mem_we = we_q;
   assign mem_wdata = wdata_q;
   assign working_register = work_q;
   assign ripple_out_bit = flags_q[FLAG_C];
   assign nibble_ripple_flag = flags_q[FLAG_NIB];
   assign result_null_flag = flags_q[FLAG_Z];
   assign signed_wrap_flag = flags_q[FLAG_WRAP];
   assign signed_result_flag = flags_q[FLAG_SIGN];
   assign multi_byte_null_flag = flags_q[FLAG_MBZ];
   assign skip_next = skip_q;
   assign op_done = done_q;

   AST_MOVE_NO_FLAGS: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_move_to_working)
      |=> (work_q == $past(mem_rdata)) && (flags_q == $past(flags_q)))
      else $error("move to working wrong value or flags");

   AST_OR_ZERO_ONLY: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_or_to_memory)
      |=> mem_we && (mem_wdata == ($past(work_q) | $past(mem_rdata)))
          && (flags_q[FLAG_C] == $past(flags_q[FLAG_C])))
      else $error("or to memory wrong");

   AST_ROTATE_LEFT: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_rotate_left)
      |=> mem_we && (mem_wdata == $past({mem_rdata[6:0], mem_rdata[7]})))
      else $error("rotate left data wrong");

   AST_ROTATE_W_KEEPS_MEM: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_rotate_right_to_working)
      |=> !mem_we && (work_q == $past({mem_rdata[0], mem_rdata[7:1]})))
      else $error("rotate to working touched memory");

   AST_RLC_RIPPLE: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_rotate_left_thru_ripple_to_working)
      |=> (ripple_out_bit == $past(mem_rdata[7]))
          && (work_q[0] == $past(flags_q[FLAG_C])))
      else $error("rotate through ripple wrong");

   AST_SUB_RIPPLE: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_subtract)
      |=> ripple_out_bit == ($past(work_q) >= $past(mem_rdata)))
      else $error("subtract ripple bit wrong");

   AST_SBCM_KEEPS_W: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_subtract_borrow_to_memory)
      |=> mem_we && (work_q == $past(work_q)))
      else $error("borrow subtract to memory changed working");

   AST_SKIP_THREE: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_FETCH && is_skip_op)
      |=> (state_q == S_EXEC) ##1 (state_q == S_DUMMY) ##1 op_ready)
      else $error("skip op not three cycles");

   AST_SET_ALL: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_all_ones)
      |=> mem_we && (mem_wdata == ALL_ONES) && (flags_q == $past(flags_q)))
      else $error("all ones write wrong");

   AST_SNZ_SKIP: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_EXEC && op_q == far_skip_nonzero)
      |=> (skip_next == ($past(mem_rdata) != ZERO_BYTE))
          && (mem_wdata == $past(mem_rdata)))
      else $error("nonzero skip wrong");

   AST_DUMMY_QUIET: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_DUMMY)
      |=> work_q == $past(work_q) && flags_q == $past(flags_q) && !mem_we)
      else $error("write during dummy cycle");

endmodule : far_op_datapath

// [logic/far_op_pkg.sv]
// constants and types for the extended data-memory op datapath
package far_op_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W_DEF = 12;
   localparam int BIT_SEL_W = 3;

   // flag vector layout
   localparam int FLAG_W = 6;
   localparam int FLAG_C = 0;
   localparam int FLAG_NIB = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_WRAP = 3;
   localparam int FLAG_SIGN = 4;
   localparam int FLAG_MBZ = 5;

   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

   // instruction-cycle costs
   localparam int PLAIN_CYCLES = 2;
   localparam int SKIP_CYCLES = 3;

   typedef enum logic [4:0] {
      far_move_to_working,
      far_move_to_memory,
      far_or_to_working,
      far_or_to_memory,
      far_rotate_left,
      far_rotate_left_to_working,
      far_rotate_left_thru_ripple,
      far_rotate_left_thru_ripple_to_working,
      far_rotate_right,
      far_rotate_right_to_working,
      far_rotate_right_thru_ripple,
      far_rotate_right_thru_ripple_to_working,
      far_subtract_borrow,
      far_subtract_borrow_to_memory,
      far_subtract,
      far_subtract_to_memory,
      far_decrement_skip_zero,
      far_decrement_skip_zero_to_working,
      far_increment_skip_zero,
      far_increment_skip_zero_to_working,
      far_all_ones,
      far_bit_set,
      far_bit_skip_set,
      far_skip_nonzero
   } op_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_FETCH,
      S_EXEC,
      S_DUMMY
   } state_t;

endpackage : far_op_pkg

// [testbench/far_op_datapath_test.sv]
// self-checking bench for the extended data-memory op datapath
`timescale 1ns/1ps

module far_op_datapath_test;
   import far_op_pkg::*;

   logic clk;
   logic rst_n;
   logic op_valid;
   logic op_ready;
   op_t op_code;
   logic [11:0] op_addr;
   logic [2:0] op_bit;
   logic [11:0] mem_addr;
   logic mem_rd;
   logic [7:0] mem_rdata;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] working_register;
   logic ripple_out_bit;
   logic nibble_ripple_flag;
   logic result_null_flag;
   logic signed_wrap_flag;
   logic signed_result_flag;
   logic multi_byte_null_flag;
   logic skip_next;
   logic op_done;
   logic [7:0] mem [0:4095];
   logic rd_q;
   logic [7:0] w_exp;
   logic [5:0] fl;
   logic [7:0] exp_m;
   logic exp_we;
   logic exp_skip;
   logic [11:0] last_a;
   logic [7:0] corner [0:3];
   int mismatches;
   int checked;
   int idx;

   far_op_datapath #(.ADDR_W(12)) dut (.clk(clk), .rst_n(rst_n),
      .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
      .op_addr(op_addr), .op_bit(op_bit), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .working_register(working_register),
      .ripple_out_bit(ripple_out_bit),
      .nibble_ripple_flag(nibble_ripple_flag),
      .result_null_flag(result_null_flag),
      .signed_wrap_flag(signed_wrap_flag),
      .signed_result_flag(signed_result_flag),
      .multi_byte_null_flag(multi_byte_null_flag),
      .skip_next(skip_next), .op_done(op_done));

   // memory answers only in the cycle after the read strobe
   always @(posedge clk) begin
      rd_q <= mem_rd;
      if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
   end
   assign mem_rdata = rd_q ? mem[mem_addr] : ~mem[mem_addr];

   function automatic logic [5:0] flags_seen();
      return {multi_byte_null_flag, signed_result_flag, signed_wrap_flag,
         result_null_flag, nibble_ripple_flag, ripple_out_bit};
   endfunction : flags_seen

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic void model(input op_t op, input logic [7:0] m,
         input logic [2:0] b);
      logic [8:0] r;
      logic [4:0] h;
      logic cin;
      logic brw;
      exp_m = m;
      exp_we = 1'b0;
      exp_skip = 1'b0;
      brw = (op == far_subtract_borrow || op == far_subtract_borrow_to_memory);
      cin = brw ? fl[FLAG_C] : 1'b1;
      r = {1'b0, w_exp} + {1'b0, ~m} + {8'h00, cin};
      h = {1'b0, w_exp[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
      case (op)
         far_move_to_working: w_exp = m;
         far_move_to_memory: {exp_m, exp_we} = {w_exp, 1'b1};
         far_or_to_working: begin
            w_exp = w_exp | m;
            fl[FLAG_Z] = (w_exp == 8'h00);
         end
         far_or_to_memory: begin
            {exp_m, exp_we} = {w_exp | m, 1'b1};
            fl[FLAG_Z] = (exp_m == 8'h00);
         end
         far_rotate_left: {exp_m, exp_we} = {m[6:0], m[7], 1'b1};
         far_rotate_left_to_working: w_exp = {m[6:0], m[7]};
         far_rotate_left_thru_ripple: begin
            {exp_m, exp_we} = {m[6:0], fl[FLAG_C], 1'b1};
            fl[FLAG_C] = m[7];
         end
         far_rotate_left_thru_ripple_to_working: begin
            w_exp = {m[6:0], fl[FLAG_C]};
            fl[FLAG_C] = m[7];
         end
         far_rotate_right: {exp_m, exp_we} = {m[0], m[7:1], 1'b1};
         far_rotate_right_to_working: w_exp = {m[0], m[7:1]};
         far_rotate_right_thru_ripple: begin
            {exp_m, exp_we} = {fl[FLAG_C], m[7:1], 1'b1};
            fl[FLAG_C] = m[0];
         end
         far_rotate_right_thru_ripple_to_working: begin
            w_exp = {fl[FLAG_C], m[7:1]};
            fl[FLAG_C] = m[0];
         end
         far_subtract_borrow, far_subtract_borrow_to_memory, far_subtract,
         far_subtract_to_memory: begin
            fl[FLAG_WRAP] = (w_exp[7] != m[7]) && (r[7] != w_exp[7]);
            fl[FLAG_C] = r[8];
            fl[FLAG_NIB] = h[4];
            fl[FLAG_Z] = (r[7:0] == 8'h00);
            fl[FLAG_SIGN] = fl[FLAG_WRAP] ^ r[7];
            fl[FLAG_MBZ] = brw ? fl[FLAG_Z] & fl[FLAG_MBZ] : fl[FLAG_Z];
            if (op == far_subtract_borrow || op == far_subtract) begin
               w_exp = r[7:0];
            end else begin
               {exp_m, exp_we} = {r[7:0], 1'b1};
            end
         end
         far_decrement_skip_zero: begin
            {exp_m, exp_we} = {m - 8'h01, 1'b1};
            exp_skip = (exp_m == 8'h00);
         end
         far_increment_skip_zero: begin
            {exp_m, exp_we} = {m + 8'h01, 1'b1};
            exp_skip = (exp_m == 8'h00);
         end
         far_decrement_skip_zero_to_working,
         far_increment_skip_zero_to_working: begin
            w_exp = (op == far_increment_skip_zero_to_working) ? m + 8'h01 :
               m - 8'h01;
            exp_skip = (w_exp == 8'h00);
         end
         far_all_ones: {exp_m, exp_we} = {ALL_ONES, 1'b1};
         far_bit_set: begin
            exp_m[b] = 1'b1;
            exp_we = 1'b1;
         end
         far_bit_skip_set: exp_skip = m[b];
         default: {exp_we, exp_skip} = {1'b1, m != 8'h00};
      endcase
   endfunction : model

   task automatic run_op(input op_t op, input logic [11:0] a,
         input logic [7:0] v, input logic [2:0] b);
      int n;
      int we_n;
      logic sk;
      logic [7:0] wd;
      logic is_skip;
      n = 0;
      we_n = 0;
      sk = 1'b0;
      wd = v;
      if (a == last_a) a = a ^ 12'h001;
      last_a = a;
      is_skip = (op >= far_decrement_skip_zero && op != far_all_ones &&
         op != far_bit_set);
      mem[a] = v;
      model(op, v, b);
      check(op_ready, 1'b1);
      op_code = op;
      op_addr = a;
      op_bit = b;
      op_valid = 1'b1;
      do begin
         @(negedge clk);
         op_valid = 1'b0;
         n++;
         if (mem_we === 1'b1) begin
            we_n++;
            wd = mem_wdata;
         end
         sk = sk | (skip_next === 1'b1);
      end while (op_done !== 1'b1 && n < 20);
      check(n, is_skip ? SKIP_CYCLES + 1 : PLAIN_CYCLES + 1);
      check(we_n, exp_we);
      check(we_n > 0 ? wd : mem[a], exp_m);
      check(sk, exp_skip);
      check(working_register, w_exp);
      check(flags_seen(), fl);
      check(mem_addr, a);
   endtask : run_op

   task automatic give_verdict();
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      check(working_register, WORK_RST);
      check(flags_seen(), FLAGS_RST);
      check({op_ready, mem_we, skip_next, op_done}, 4'h8);
      rst_n = 1'b1;
      w_exp = WORK_RST;
      fl = FLAGS_RST;
   endtask : do_reset

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      {op_valid, op_addr, op_bit, mismatches, checked} = '0;
      op_code = far_move_to_working;
      last_a = 12'h555;
      corner = '{8'h00, 8'hFF, 8'h80, 8'h01};
      void'($urandom(32'hbb531647));
      for (int i = 0; i < 4096; i++) mem[i] = 8'($urandom);
      do_reset();
      idx = 0;
      for (int k = 0; k < 24; k++) begin
         for (int j = 0; j < 4; j++) begin
            run_op(op_t'(k), idx[0] ? 12'hFFF : 12'h000, corner[j], 3'(k));
            idx++;
         end
      end
      for (int i = 0; i < 300; i++) begin
         if (i == 150) do_reset();
         run_op(op_t'($urandom_range(0, 23)), 12'($urandom),
            ($urandom_range(0, 3) == 0) ? corner[$urandom_range(0, 3)] :
            8'($urandom), 3'($urandom));
      end
      give_verdict();
   end

endmodule : far_op_datapath_test
